/* File: rtl/wtv_dpram.sv */
// Dual-port register storage with registered read data
`timescale 1ns/1ns
module wtv_dpram #(
   parameter int AW = 10,
   parameter int DW = 16
) (
   // Clock
   input  wire logic          clk_i,
   // Processor port
   input  wire logic          a_en_i,
   input  wire logic          a_we_i,
   input  wire logic [AW-1:0] a_addr_i,
   input  wire logic [DW-1:0] a_wdata_i,
   output logic      [DW-1:0] a_rdata_o,
   // Engine port
   input  wire logic          b_en_i,
   input  wire logic          b_we_i,
   input  wire logic [AW-1:0] b_addr_i,
   input  wire logic [DW-1:0] b_wdata_i,
   output logic      [DW-1:0] b_rdata_o
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Processor write lands last, so it wins a same-word collision
   always_ff @(posedge clk_i)
   begin
      if (b_en_i && b_we_i)
         mem[b_addr_i] <= b_wdata_i;
      if (a_en_i && a_we_i)
         mem[a_addr_i] <= a_wdata_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (a_en_i)
         a_rdata_o <= mem[a_addr_i];
      if (b_en_i)
         b_rdata_o <= mem[b_addr_i];
   end
endmodule : wtv_dpram

/* File: rtl/wtv_pkg.sv */
// Constants shared by the wavetable voice register bank
package wtv_pkg;
   // Register offsets on voice pages
   localparam logic [3:0] OFS_VOICE_CONTROL    = 4'h0;
   localparam logic [3:0] OFS_CUTOFF_UPPER     = 4'h6;
   localparam logic [3:0] OFS_CUTOFF_LOWER     = 4'h7;
   localparam logic [3:0] OFS_CHANNEL_FILTER   = 4'h9;
   localparam logic [3:0] OFS_ACCUM_HIGH       = 4'hA;
   localparam logic [3:0] OFS_ACCUM_LOW        = 4'hB;
   localparam logic [3:0] OFS_LAST_VOICE_REG   = 4'hB;
   // Global offsets, present on every page
   localparam logic [3:0] OFS_CONVERTER        = 4'hC;
   localparam logic [3:0] OFS_ACTIVE_COUNT     = 4'hD;
   localparam logic [3:0] OFS_VECTOR           = 4'hE;
   localparam logic [3:0] OFS_PAGE_SELECT      = 4'hF;
   // Filter storage offsets
   localparam logic [3:0] OFS_STAGE4_LAST      = 4'h1;
   localparam logic [3:0] OFS_STAGE3_PRIOR     = 4'h2;
   localparam logic [3:0] OFS_STAGE3_LAST      = 4'h3;
   localparam logic [3:0] OFS_STAGE2_PRIOR     = 4'h4;
   localparam logic [3:0] OFS_STAGE2_LAST      = 4'h5;
   localparam logic [3:0] OFS_STAGE1_LAST      = 4'h6;
   // Page ranges
   localparam logic [5:0] PAGE_LAST_VOICE      = 6'h18;
   localparam logic [5:0] PAGE_FILTER_FIRST    = 6'h20;
   localparam logic [5:0] PAGE_FILTER_LAST     = 6'h39;
   // Field positions
   localparam int CHAN_MSB                     = 3;
   localparam int POLE3_LP_BIT                 = 4;
   localparam int POLE4_LP_BIT                 = 5;
   localparam int PHASE_ACCUM_HIGH_WIDTH                   = 13;
   localparam int FRAC_WIDTH                   = 9;
   localparam int FETCH_WIDTH                  = 20;
   localparam int COEFF_LSB                    = 4;
   localparam int CONV_LADDER_TEST_BIT         = 0;
   localparam int CONV_WRITE_EN_BIT            = 1;
   localparam int CONV_ONE_BIT                 = 2;
   localparam int CONV_DATA_LSB                = 3;
   localparam int VEC_EMPTY_BIT                = 7;
   // Read fill of unused upper bits
   localparam logic [15:0] CONTROL_FILL        = 16'hFF00;
   localparam logic [15:0] CHANNEL_FILL        = 16'hFFC0;
   localparam logic [15:0] VECTOR_FILL         = 16'hFF60;
   // Reset values
   localparam logic [15:0] CONVERTER_RESET     = 16'h0000;
   localparam logic [4:0]  ACTIVE_RESET        = 5'h18;
   localparam logic [4:0]  VECTOR_RESET        = 5'h00;
   localparam logic [5:0]  PAGE_RESET          = 6'h00;
   // Timing
   localparam int CLK_PERIOD_NS                = 20;
   localparam int VOICE_TIME_NS                = 1600;
   localparam int VOICE_CYCLES                 = VOICE_TIME_NS / CLK_PERIOD_NS;
   // Engine sequence lengths
   localparam int READ_WORDS                   = 11;
   localparam int WRITE_WORDS                  = 6;
endpackage : wtv_pkg

/* File: rtl/wtv_regs.sv */
// Wavetable voice and filter storage register bank with voice scan
`timescale 1ns/1ns
module wtv_regs #(
   parameter int SLOT_CYCLES = wtv_pkg::VOICE_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // Processor bus, asynchronous to clk_i
   input  wire logic        cs_n_i,
   input  wire logic        rd_not_wr_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] data_i,
   output logic      [15:0] data_o,
   output logic             data_oe_n_o,
   output logic             dtack_n_o,
   // Voice presentation to the engine
   output logic             voice_strobe_o,
   output logic      [4:0]  voice_num_o,
   output logic      [3:0]  chan_code_o,
   output logic      [19:0] fetch_addr_o,
   output logic      [8:0]  frac_phase_o,
   output logic             pole3_lowpass_o,
   output logic             pole4_lowpass_o,
   output logic      [11:0] pole12_coeff_o,
   output logic      [11:0] pole3_coeff_o,
   output logic      [11:0] pole4_coeff_o,
   output logic      [15:0] stage1_last_o,
   output logic      [15:0] stage2_last_o,
   output logic      [15:0] stage2_prior_o,
   output logic      [15:0] stage3_last_o,
   output logic      [15:0] stage3_prior_o,
   output logic      [15:0] dac_word_o,
   // New filter outputs from the engine
   input  wire logic        result_valid_i,
   input  wire logic [15:0] new_stage1_i,
   input  wire logic [15:0] new_stage2_i,
   input  wire logic [15:0] new_stage3_i,
   input  wire logic [15:0] new_stage4_i
);
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_RDWT = 3'b010,
      BUS_HOLD = 3'b100
   } wtv_bus_t;

   typedef enum logic [4:0] {
      ENG_IDLE = 5'b00001,
      ENG_READ = 5'b00010,
      ENG_LOAD = 5'b00100,
      ENG_WAIT = 5'b01000,
      ENG_WRIT = 5'b10000
   } wtv_eng_t;

   // Reset release
   logic rst_s1_reg;
   logic rst_n;
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // Bus pin synchronisers
   logic [21:0] pin_s1_reg;
   logic [21:0] pin_s2_reg;
   logic        cs_prev_reg;
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_reg  <= 22'h000001;
         pin_s2_reg  <= 22'h000001;
         cs_prev_reg <= 1'b1;
      end
      else
      begin
         pin_s1_reg  <= {data_i, addr_i, rd_not_wr_i, cs_n_i};
         pin_s2_reg  <= pin_s1_reg;
         cs_prev_reg <= pin_s2_reg[0];
      end
   end

   logic        cs_n_s;
   logic        rd_s;
   logic [3:0]  addr_s;
   logic [15:0] wdata_s;
   logic        bus_start;
   assign cs_n_s    = pin_s2_reg[0];
   assign rd_s      = pin_s2_reg[1];
   assign addr_s    = pin_s2_reg[5:2];
   assign wdata_s   = pin_s2_reg[21:6];
   assign bus_start = cs_prev_reg && !cs_n_s;

   // Global registers and page select
   logic [15:0] conv_reg;
   logic [4:0]  act_reg;
   logic [4:0]  vec_reg;
   logic        vec_empty_reg;
   logic [5:0]  page_reg;
   logic        is_global;
   logic        voice_page;
   logic        filt_page;
   logic        mapped;

   assign is_global  = addr_s >= wtv_pkg::OFS_CONVERTER;
   assign voice_page = page_reg <= wtv_pkg::PAGE_LAST_VOICE;
   assign filt_page  = page_reg >= wtv_pkg::PAGE_FILTER_FIRST && page_reg <= wtv_pkg::PAGE_FILTER_LAST;
   assign mapped     = (voice_page && addr_s <= wtv_pkg::OFS_LAST_VOICE_REG)
                    || (filt_page && addr_s >= wtv_pkg::OFS_STAGE4_LAST
                        && addr_s <= wtv_pkg::OFS_STAGE1_LAST);

   logic glob_wr;
   logic glob_rd;
   assign glob_wr = bus_start && !rd_s && is_global;
   assign glob_rd = bus_start && rd_s && is_global;

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         conv_reg <= wtv_pkg::CONVERTER_RESET;
         act_reg  <= wtv_pkg::ACTIVE_RESET;
         page_reg <= wtv_pkg::PAGE_RESET;
         vec_reg  <= wtv_pkg::VECTOR_RESET;
      end
      else if (glob_wr)
      begin
         unique case (addr_s)
            wtv_pkg::OFS_CONVERTER:
            begin
               conv_reg[wtv_pkg::CONV_WRITE_EN_BIT:0] <= wdata_s[wtv_pkg::CONV_WRITE_EN_BIT:0];
               if (conv_reg[wtv_pkg::CONV_WRITE_EN_BIT])
                  conv_reg[15:wtv_pkg::CONV_DATA_LSB] <= wdata_s[15:wtv_pkg::CONV_DATA_LSB];
            end
            wtv_pkg::OFS_ACTIVE_COUNT: act_reg  <= wdata_s[4:0];
            wtv_pkg::OFS_VECTOR:       vec_reg  <= wdata_s[4:0];
            wtv_pkg::OFS_PAGE_SELECT:  page_reg <= wdata_s[5:0];
            default:                   ;
         endcase
      end
   end

   // Reading the vector marks it empty
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         vec_empty_reg <= 1'b1;
      else if (glob_rd && addr_s == wtv_pkg::OFS_VECTOR)
         vec_empty_reg <= 1'b1;
      else if (glob_wr && addr_s == wtv_pkg::OFS_VECTOR)
         vec_empty_reg <= wdata_s[wtv_pkg::VEC_EMPTY_BIT];
   end

   logic [15:0] glob_rdata;
   always_comb
   begin
      glob_rdata = 16'h0000;
      unique case (addr_s)
         wtv_pkg::OFS_CONVERTER:    glob_rdata = conv_reg | (16'h0001 << wtv_pkg::CONV_ONE_BIT);
         wtv_pkg::OFS_ACTIVE_COUNT: glob_rdata = {11'h000, act_reg};
         wtv_pkg::OFS_VECTOR:
         begin
            glob_rdata = wtv_pkg::VECTOR_FILL | {11'h000, vec_reg};
            glob_rdata[wtv_pkg::VEC_EMPTY_BIT] = vec_empty_reg;
         end
         wtv_pkg::OFS_PAGE_SELECT:  glob_rdata = {10'h000, page_reg};
         default:                   glob_rdata = 16'h0000;
      endcase
   end

   // Processor port of the storage
   logic        a_en;
   logic        a_we;
   logic [9:0]  a_addr;
   logic [15:0] a_rdata;
   assign a_en   = bus_start && !is_global && mapped;
   assign a_we   = !rd_s;
   assign a_addr = {page_reg, addr_s};

   // Processor bus handshake
   wtv_bus_t    bus_state_reg;
   logic [3:0]  rd_ofs_reg;
   logic        rd_map_reg;
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_state_reg <= BUS_IDLE;
         data_o        <= 16'h0000;
         data_oe_n_o   <= 1'b1;
         dtack_n_o     <= 1'b1;
         rd_ofs_reg    <= 4'h0;
         rd_map_reg    <= 1'b0;
      end
      else
      begin
         unique case (bus_state_reg)
            BUS_IDLE:
               if (bus_start)
               begin
                  rd_ofs_reg <= addr_s;
                  rd_map_reg <= mapped;
                  if (rd_s && !is_global)
                     bus_state_reg <= BUS_RDWT;
                  else
                  begin
                     data_o        <= glob_rdata;
                     data_oe_n_o   <= !rd_s;
                     dtack_n_o     <= 1'b0;
                     bus_state_reg <= BUS_HOLD;
                  end
               end
            BUS_RDWT:
            begin
               if (!rd_map_reg)
                  data_o <= 16'h0000;
               else if (rd_ofs_reg == wtv_pkg::OFS_VOICE_CONTROL && !page_reg[5])
                  data_o <= a_rdata | wtv_pkg::CONTROL_FILL;
               else if (rd_ofs_reg == wtv_pkg::OFS_CHANNEL_FILTER)
                  data_o <= a_rdata | wtv_pkg::CHANNEL_FILL;
               else
                  data_o <= a_rdata;
               data_oe_n_o   <= 1'b0;
               dtack_n_o     <= 1'b0;
               bus_state_reg <= BUS_HOLD;
            end
            BUS_HOLD:
               if (cs_n_s)
               begin
                  data_oe_n_o   <= 1'b1;
                  dtack_n_o     <= 1'b1;
                  bus_state_reg <= BUS_IDLE;
               end
            default: bus_state_reg <= BUS_IDLE;
         endcase
      end
   end

   // Voice slot divider
   logic [15:0] slot_cnt_reg;
   logic        slot_en;
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         slot_cnt_reg <= 16'h0000;
      else if (slot_cnt_reg == 16'(SLOT_CYCLES - 1))
         slot_cnt_reg <= 16'h0000;
      else
         slot_cnt_reg <= slot_cnt_reg + 16'h0001;
   end
   assign slot_en = slot_cnt_reg == 16'h0000;

   // Voice scan sequencer
   wtv_eng_t    eng_state_reg;
   logic [3:0]  step_reg;
   logic [3:0]  cap_idx_reg;
   logic        cap_reg;
   logic [4:0]  voice_reg;
   logic [15:0] words_reg [0:wtv_pkg::READ_WORDS-1];
   logic [15:0] new_reg   [0:3];
   logic        b_en;
   logic        b_we;
   logic [9:0]  b_addr;
   logic [15:0] b_wdata;
   logic [15:0] b_rdata;
   logic [5:0]  filt_pg;

   assign filt_pg = wtv_pkg::PAGE_FILTER_FIRST + {1'b0, voice_reg};

   // Read order: channel, accum high, accum low, lower and upper coeff, then offsets 1..6
   always_comb
   begin
      b_en    = 1'b0;
      b_we    = 1'b0;
      b_addr  = 10'h000;
      b_wdata = 16'h0000;
      if (eng_state_reg == ENG_READ)
      begin
         b_en = step_reg < 4'(wtv_pkg::READ_WORDS);
         unique case (step_reg)
            4'h0: b_addr = {1'b0, voice_reg, wtv_pkg::OFS_CHANNEL_FILTER};
            4'h1: b_addr = {1'b0, voice_reg, wtv_pkg::OFS_ACCUM_HIGH};
            4'h2: b_addr = {1'b0, voice_reg, wtv_pkg::OFS_ACCUM_LOW};
            4'h3: b_addr = {1'b0, voice_reg, wtv_pkg::OFS_CUTOFF_LOWER};
            4'h4: b_addr = {1'b0, voice_reg, wtv_pkg::OFS_CUTOFF_UPPER};
            default: b_addr = {filt_pg, 4'(step_reg - 4'h4)};
         endcase
      end
      else if (eng_state_reg == ENG_WRIT)
      begin
         b_en   = 1'b1;
         b_we   = 1'b1;
         b_addr = {filt_pg, 4'(step_reg + 4'h1)};
         unique case (step_reg)
            4'h0: b_wdata = new_reg[3];
            4'h1: b_wdata = words_reg[7];
            4'h2: b_wdata = new_reg[2];
            4'h3: b_wdata = words_reg[9];
            4'h4: b_wdata = new_reg[1];
            default: b_wdata = new_reg[0];
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         eng_state_reg <= ENG_IDLE;
         step_reg      <= 4'h0;
         voice_reg     <= 5'h00;
         cap_reg       <= 1'b0;
         cap_idx_reg   <= 4'h0;
      end
      else
      begin
         cap_reg     <= b_en && !b_we;
         cap_idx_reg <= step_reg;
         unique case (eng_state_reg)
            ENG_IDLE:
               if (slot_en)
               begin
                  step_reg      <= 4'h0;
                  eng_state_reg <= ENG_READ;
               end
            ENG_READ:
               if (step_reg == 4'(wtv_pkg::READ_WORDS))
                  eng_state_reg <= ENG_LOAD;
               else
                  step_reg <= step_reg + 4'h1;
            ENG_LOAD: eng_state_reg <= ENG_WAIT;
            ENG_WAIT:
               if (result_valid_i)
               begin
                  step_reg      <= 4'h0;
                  eng_state_reg <= ENG_WRIT;
               end
            ENG_WRIT:
               if (step_reg == 4'(wtv_pkg::WRITE_WORDS - 1))
               begin
                  voice_reg     <= (voice_reg >= act_reg) ? 5'h00 : voice_reg + 5'h01;
                  eng_state_reg <= ENG_IDLE;
               end
               else
                  step_reg <= step_reg + 4'h1;
            default: eng_state_reg <= ENG_IDLE;
         endcase
      end
   end

   // Captured words and engine results
   always_ff @(posedge clk_i)
   begin
      if (cap_reg)
         words_reg[cap_idx_reg] <= b_rdata;
      if (eng_state_reg == ENG_WAIT && result_valid_i)
      begin
         new_reg[0] <= new_stage1_i;
         new_reg[1] <= new_stage2_i;
         new_reg[2] <= new_stage3_i;
         new_reg[3] <= new_stage4_i;
      end
   end

   // Presented voice, held until the next voice loads
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         voice_strobe_o  <= 1'b0;
         voice_num_o     <= 5'h00;
         chan_code_o     <= 4'h0;
         fetch_addr_o    <= 20'h00000;
         frac_phase_o    <= 9'h000;
         pole3_lowpass_o <= 1'b0;
         pole4_lowpass_o <= 1'b0;
         pole12_coeff_o  <= 12'h000;
         pole3_coeff_o   <= 12'h000;
         pole4_coeff_o   <= 12'h000;
         stage1_last_o   <= 16'h0000;
         stage2_last_o   <= 16'h0000;
         stage2_prior_o  <= 16'h0000;
         stage3_last_o   <= 16'h0000;
         stage3_prior_o  <= 16'h0000;
         dac_word_o      <= 16'h0000;
      end
      else
      begin
         voice_strobe_o <= eng_state_reg == ENG_LOAD;
         if (eng_state_reg == ENG_LOAD)
         begin
            voice_num_o     <= voice_reg;
            chan_code_o     <= words_reg[0][wtv_pkg::CHAN_MSB:0];
            pole3_lowpass_o <= words_reg[0][wtv_pkg::POLE3_LP_BIT];
            pole4_lowpass_o <= words_reg[0][wtv_pkg::POLE4_LP_BIT];
            fetch_addr_o    <= {words_reg[1][wtv_pkg::PHASE_ACCUM_HIGH_WIDTH-1:0],
                                words_reg[2][15:wtv_pkg::FRAC_WIDTH]};
            frac_phase_o    <= words_reg[2][wtv_pkg::FRAC_WIDTH-1:0];
            pole12_coeff_o  <= words_reg[3][15:wtv_pkg::COEFF_LSB];
            // Pole three follows its own mode bit: lowpass uses the lower pair's coefficient
            pole3_coeff_o   <= words_reg[0][wtv_pkg::POLE3_LP_BIT]
                               ? words_reg[3][15:wtv_pkg::COEFF_LSB]
                               : words_reg[4][15:wtv_pkg::COEFF_LSB];
            pole4_coeff_o   <= words_reg[4][15:wtv_pkg::COEFF_LSB];
            dac_word_o      <= words_reg[5];
            stage3_prior_o  <= words_reg[6];
            stage3_last_o   <= words_reg[7];
            stage2_prior_o  <= words_reg[8];
            stage2_last_o   <= words_reg[9];
            stage1_last_o   <= words_reg[10];
         end
      end
   end

   wtv_dpram #(
      .AW (10),
      .DW (16)
   ) u_store (
      .clk_i     (clk_i),
      .a_en_i    (a_en),
      .a_we_i    (a_we),
      .a_addr_i  (a_addr),
      .a_wdata_i (wdata_s),
      .a_rdata_o (a_rdata),
      .b_en_i    (b_en),
      .b_we_i    (b_we),
      .b_addr_i  (b_addr),
      .b_wdata_i (b_wdata),
      .b_rdata_o (b_rdata)
   );
endmodule : wtv_regs

/* File: testbench/wtv_cpu_model.sv */
// Processor model on the asynchronous register bus
`timescale 1ns/1ns
module wtv_cpu_model (
   // Clock
   input wire logic        clk_i,
   // Bus to the device
   output logic            cs_n_o,
   output logic            rd_not_wr_o,
   output logic     [3:0]  addr_o,
   output logic     [15:0] data_o,
   input wire logic [15:0] data_i,
   input wire logic        data_oe_n_i,
   input wire logic        dtack_n_i
);
   initial
   begin
      cs_n_o = 1'b1;
      rd_not_wr_o = 1'b1;
      addr_o = 4'h0;
      data_o = 16'h0000;
   end
   // Holds the request until acknowledge is sampled, then releases
   task automatic access(input logic rd, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
      int n;
      @(posedge clk_i);
      #1;
      cs_n_o = 1'b0;
      rd_not_wr_o = rd;
      addr_o = a;
      data_o = d;
      q = 'x;
      n = 0;
      do begin @(posedge clk_i); n++; end while (dtack_n_i !== 1'b0 && n < 40);
      if (dtack_n_i === 1'b0 && data_oe_n_i === 1'b0) q = data_i;
      #1;
      cs_n_o = 1'b1;
      // Released bus must not keep showing the old word
      data_o = ~data_o;
      n = 0;
      while (dtack_n_i !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
      repeat (3) @(posedge clk_i);
   endtask : access
endmodule : wtv_cpu_model

/* File: testbench/wtv_regs_sva.sv */
// Port assertions for the wavetable voice register bank
`timescale 1ns/1ns
module wtv_regs_sva (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   // Processor bus
   input wire logic        cs_n_i,
   input wire logic        rd_not_wr_i,
   input wire logic        data_oe_n_o,
   input wire logic        dtack_n_o,
   // Voice outputs
   input wire logic        voice_strobe_o,
   input wire logic [3:0]  chan_code_o,
   input wire logic        pole3_lowpass_o,
   input wire logic        pole4_lowpass_o,
   input wire logic [11:0] pole12_coeff_o,
   input wire logic [11:0] pole3_coeff_o,
   input wire logic [11:0] pole4_coeff_o,
   input wire logic [15:0] dac_word_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_select;
      cs_n_i ##1 !cs_n_i;
   endsequence
   sequence s_bus_idle;
      cs_n_i [*5];
   endsequence
   AST_POLE3_UPPER: assert property (!pole3_lowpass_o |-> pole3_coeff_o == pole4_coeff_o)
      else $error("pole three not on upper coefficient");
   AST_POLE3_LOWER: assert property (pole3_lowpass_o |-> pole3_coeff_o == pole12_coeff_o)
      else $error("pole three not on lower coefficient");
   AST_CHAN_HOLD: assert property (!voice_strobe_o |-> $stable(chan_code_o))
      else $error("channel code moved between voices");
   AST_DAC_HOLD: assert property (!voice_strobe_o |-> $stable(dac_word_o))
      else $error("dac word moved between voices");
   AST_STROBE_PULSE: assert property (voice_strobe_o |=> !voice_strobe_o [*8])
      else $error("voice strobe not a single pulse");
   AST_ACK: assert property (s_select |-> ##[2:6] !dtack_n_o)
      else $error("access not acknowledged");
   AST_RELEASE: assert property (s_bus_idle |-> dtack_n_o)
      else $error("acknowledge held after release");
   AST_READ_DRIVE: assert property ($fell(data_oe_n_o) |-> rd_not_wr_i && !cs_n_i)
      else $error("data driven outside a read");
endmodule : wtv_regs_sva
bind wtv_regs wtv_regs_sva chk_u (.clk_i, .reset_n_i, .cs_n_i, .rd_not_wr_i, .data_oe_n_o, .dtack_n_o,
   .voice_strobe_o, .chan_code_o, .pole3_lowpass_o, .pole4_lowpass_o, .pole12_coeff_o, .pole3_coeff_o,
   .pole4_coeff_o,
   .dac_word_o);

/* File: testbench/wtv_regs_tb.sv */
// Self-checking testbench for the wavetable voice register bank
`timescale 1ns/1ns
module wtv_regs_tb;
   logic        clk_i, reset_n_i, cs_n_i, rd_not_wr_i, data_oe_n_o, dtack_n_o, voice_strobe_o;
   logic        pole3_lowpass_o, pole4_lowpass_o, result_valid_i;
   logic [3:0]  addr_i, chan_code_o;
   logic [4:0]  voice_num_o;
   logic [8:0]  frac_phase_o;
   logic [11:0] pole12_coeff_o, pole3_coeff_o, pole4_coeff_o;
   logic [15:0] data_i, data_o, q, v, stage1_last_o, stage2_last_o, stage2_prior_o, stage3_last_o;
   logic [15:0] stage3_prior_o, dac_word_o, new_stage1_i, new_stage2_i, new_stage3_i, new_stage4_i;
   logic [19:0] fetch_addr_o;
   int          num_errors = 0;
   int          cmp_count = 0;
   wtv_regs #(.SLOT_CYCLES(32)) dut_u (.clk_i, .reset_n_i, .cs_n_i, .rd_not_wr_i, .addr_i, .data_i, .data_o,
      .data_oe_n_o, .dtack_n_o, .voice_strobe_o, .voice_num_o, .chan_code_o, .fetch_addr_o, .frac_phase_o,
      .pole3_lowpass_o, .pole4_lowpass_o, .pole12_coeff_o, .pole3_coeff_o, .pole4_coeff_o, .stage1_last_o,
      .stage2_last_o, .stage2_prior_o, .stage3_last_o, .stage3_prior_o, .dac_word_o, .result_valid_i,
      .new_stage1_i, .new_stage2_i, .new_stage3_i, .new_stage4_i);
   wtv_cpu_model cpu_u (.clk_i, .cs_n_o(cs_n_i), .rd_not_wr_o(rd_not_wr_i), .addr_o(addr_i), .data_o(data_i),
      .data_i(data_o), .data_oe_n_i(data_oe_n_o), .dtack_n_i(dtack_n_o));
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
      cpu_u.access(1'b1, a, 16'h0000, q);
      chk(n, 32'(e), 32'(q));
   endtask : rd
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      cpu_u.access(1'b0, a, d, q);
   endtask : wr
   // Stops on the strobe of voice zero, outputs already settled
   task automatic wait_voice0();
      int n;
      n = 0;
      do begin @(posedge clk_i); #1; n++; end while (!(voice_strobe_o === 1'b1 && voice_num_o === 5'h00) && n < 2000);
      if (voice_strobe_o !== 1'b1 || voice_num_o !== 5'h00)
      begin
         num_errors++;
         $display("Error voice0 strobe expected 1 seen 0");
      end
   endtask : wait_voice0
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Engine stand-in: answers each strobe with per-voice stage words
   always
   begin
      @(posedge clk_i);
      #1;
      if (voice_strobe_o === 1'b1)
      begin
         new_stage1_i = 16'h1100 + 16'(voice_num_o);
         new_stage2_i = 16'h2200 + 16'(voice_num_o);
         new_stage3_i = 16'h3300 + 16'(voice_num_o);
         new_stage4_i = 16'h4400 + 16'(voice_num_o);
         @(posedge clk_i);
         #1 result_valid_i = 1'b1;
         @(posedge clk_i);
         #1 result_valid_i = 1'b0;
      end
   end
   initial
   begin
      repeat (40000) @(posedge clk_i);
      num_errors++;
      end_of_test();
   end
   initial
   begin
      reset_n_i = 1'b0;
      result_valid_i = 1'b0;
      {new_stage1_i, new_stage2_i, new_stage3_i, new_stage4_i} = 64'h0;
      repeat (16) @(posedge clk_i);
      #1 reset_n_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rd(4'hD, 16'h0018, "active count");
      rd(4'hE, 16'hFFE0, "vector");
      rd(4'hC, 16'h0004, "converter");
      $display("test globals done");
      wr(4'h6, 16'hABC0);
      wr(4'h7, 16'h1230);
      wr(4'hF, 16'h0001);
      wr(4'h9, 16'h0005);
      wr(4'hF, 16'h0000);
      for (int m = 0; m < 4; m++)
      begin
         v = {10'h0, 2'(m), 4'(12 - m)};
         wr(4'h9, v);
         rd(4'h9, v | 16'hFFC0, "channel reg");
         wait_voice0();
         chk("chan", 32'(v[3:0]), 32'(chan_code_o));
         chk("p3 lp", 32'(v[4]), 32'(pole3_lowpass_o));
         chk("p4 lp", 32'(v[5]), 32'(pole4_lowpass_o));
         chk("k12", 32'h123, 32'(pole12_coeff_o));
         chk("k3", v[4] ? 32'h123 : 32'hABC, 32'(pole3_coeff_o));
         chk("k4", 32'hABC, 32'(pole4_coeff_o));
      end
      wr(4'hF, 16'h0001);
      rd(4'h9, 16'hFFC5, "page one chan");
      wr(4'hF, 16'h0000);
      $display("test filter modes done");
      wr(4'hA, 16'h1ABC);
      wr(4'hB, 16'hDEF5);
      rd(4'hA, 16'h1ABC, "accum high");
      rd(4'hB, 16'hDEF5, "accum low");
      wait_voice0();
      chk("fetch", 32'h000D_5E6F, 32'(fetch_addr_o));
      chk("frac", 32'h0F5, 32'(frac_phase_o));
      $display("test accumulator done");
      repeat (12) @(posedge clk_i);
      wr(4'hF, 16'h0020);
      for (int i = 1; i < 7; i++) wr(4'(i), 16'hA000 + 16'(i));
      rd(4'h3, 16'hA003, "storage 3");
      rd(4'h0, 16'h0000, "filter page hole");
      rd(4'hD, 16'h0018, "global on filter page");
      wait_voice0();
      chk("dac", 32'hA001, 32'(dac_word_o));
      chk("s3 prior", 32'hA002, 32'(stage3_prior_o));
      chk("s3 last", 32'hA003, 32'(stage3_last_o));
      chk("s2 prior", 32'hA004, 32'(stage2_prior_o));
      chk("s2 last", 32'hA005, 32'(stage2_last_o));
      chk("s1 last", 32'hA006, 32'(stage1_last_o));
      repeat (12) @(posedge clk_i);
      rd(4'h1, 16'h4400, "new stage 4");
      rd(4'h2, 16'hA003, "shifted stage 3");
      rd(4'h3, 16'h3300, "new stage 3");
      rd(4'h4, 16'hA005, "shifted stage 2");
      rd(4'h5, 16'h2200, "new stage 2");
      rd(4'h6, 16'h1100, "new stage 1");
      wr(4'hF, 16'h003A);
      rd(4'h1, 16'h0000, "page 58");
      wr(4'hF, 16'h0019);
      rd(4'h6, 16'h0000, "page 25");
      $display("test filter storage done");
      end_of_test();
   end
endmodule : wtv_regs_tb
